// ---- rtl/ppcl_pkg.sv ----
// ****************************************************************
// Loader constants
// ****************************************************************
package ppcl_pkg;

  // Clock period of the loader
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EXP_WORDS = 8'h04;
  localparam logic [7:0] REG_EXP_CHECK = 8'h08;
  localparam logic [7:0] REG_KEY = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_WORD_COUNT = 8'h14;
  localparam logic [7:0] REG_LAST_WORD = 8'h18;

  // Control field positions
  localparam int unsigned CTRL_WIDTH_LSB = 0;
  localparam int unsigned CTRL_DECOMP_BIT = 2;
  localparam int unsigned CTRL_SECURE_BIT = 3;
  localparam int unsigned CTRL_USRCLK_BIT = 4;
  localparam int unsigned CTRL_INITDONE_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Width mode encodings
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // Status field positions
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_ERROR_BIT = 3;
  localparam int unsigned STAT_RATIO_LSB = 4;

  // Times in their own units
  localparam int unsigned STATUS_MIN_US = 268;
  localparam int unsigned INIT_OSC_MIN_US = 175;
  localparam int unsigned CFG_CLK_MAX_PERIOD_NS = 10;
  localparam int unsigned CU_PERIODS = 4;
  localparam int unsigned USER_INIT_PERIODS = 8576;
  localparam int unsigned DONE_FALL_EDGES = 2;

  // Derived cycle counts, least times rounded up
  localparam int unsigned STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int unsigned INIT_OSC_CYC = (INIT_OSC_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
  localparam int unsigned CU_CYC_RAW = (CU_PERIODS * CFG_CLK_MAX_PERIOD_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
  localparam int unsigned CU_CYC = (CU_CYC_RAW < 1) ? 1 : CU_CYC_RAW;

  // Loader states, Gray along the usual path
  typedef enum logic [2:0] {
    PPCL_POR = 3'h0,
    PPCL_CLEAR = 3'h1,
    PPCL_LOAD = 3'h3,
    PPCL_DONE = 3'h2,
    PPCL_INIT = 3'h6,
    PPCL_USER = 3'h7,
    PPCL_ERROR = 3'h5
  } ppcl_state_t;

endpackage

// ---- rtl/ppcl_loader.sv ----
`timescale 1ns/1ps
`default_nettype none

module ppcl_loader #(
  parameter int unsigned POR_CYCLES = ppcl_pkg::STATUS_MIN_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Configuration pins
  input wire logic config_clock,
  input wire logic [31:0] config_data,
  input wire logic reload_request_n,
  input wire logic loader_status_n_in,
  output logic loader_status_n_out,
  output logic loader_status_n_oe,
  output logic load_complete,
  input wire logic user_init_clock,
  output logic init_done_out,
  output logic init_done_oe,
  // Processed configuration words
  output logic [31:0] cfg_word,
  output logic cfg_word_valid
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Settled level: change counts when last two stages agree
  function automatic logic settle(input logic stable, input logic s2, input logic s3);
    settle = (s2 == s3) ? s3 : stable;
  endfunction

  // Clocks per word from width, decompression, security
  function automatic logic [3:0] ratio_f(input logic [1:0] width, input logic decomp,
                                         input logic secure);
    case (width)
      ppcl_pkg::WIDTH_8: ratio_f = decomp ? 4'h2 : 4'h1;
      ppcl_pkg::WIDTH_16: ratio_f = decomp ? 4'h4 : (secure ? 4'h2 : 4'h1);
      default: ratio_f = decomp ? 4'h8 : (secure ? 4'h4 : 4'h1);
    endcase
  endfunction

  // Lane mask for the chosen width
  function automatic logic [31:0] lanes_f(input logic [1:0] width);
    case (width)
      ppcl_pkg::WIDTH_8: lanes_f = 32'h0000_00FF;
      ppcl_pkg::WIDTH_16: lanes_f = 32'h0000_FFFF;
      default: lanes_f = 32'hFFFF_FFFF;
    endcase
  endfunction

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************

  logic [1:0] rst_sync_q; // Reset release chain
  logic rst_sync_n; // Released reset copy

  // Two-flop reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  logic [2:0] cclk_s_q; // Config clock stages
  logic [2:0] uclk_s_q; // User clock stages
  logic [2:0] req_s_q; // Request stages
  logic [2:0] stat_s_q; // Status input stages
  logic [31:0] data_s1_q; // Data stage one
  logic [31:0] data_s2_q; // Data stage two
  logic [31:0] data_s3_q; // Data stage three, aligned with clock

  // Three-stage synchronisers
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cclk_s_q <= 3'h0;
      uclk_s_q <= 3'h0;
      req_s_q <= 3'h7;
      stat_s_q <= 3'h0;
      data_s1_q <= 32'h0000_0000;
      data_s2_q <= 32'h0000_0000;
      data_s3_q <= 32'h0000_0000;
    end else begin
      cclk_s_q <= {cclk_s_q[1:0], config_clock};
      uclk_s_q <= {uclk_s_q[1:0], user_init_clock};
      req_s_q <= {req_s_q[1:0], reload_request_n};
      stat_s_q <= {stat_s_q[1:0], loader_status_n_in};
      data_s1_q <= config_data;
      data_s2_q <= data_s1_q;
      data_s3_q <= data_s2_q;
    end
  end

  logic cclk_q; // Settled config clock
  logic uclk_q; // Settled user clock
  logic req_q; // Settled request level
  logic stat_q; // Settled status level
  logic cclk_d;
  logic uclk_d;
  logic req_d;
  logic stat_d;

  assign cclk_d = settle(cclk_q, cclk_s_q[1], cclk_s_q[2]);
  assign uclk_d = settle(uclk_q, uclk_s_q[1], uclk_s_q[2]);
  assign req_d = settle(req_q, req_s_q[1], req_s_q[2]);
  assign stat_d = settle(stat_q, stat_s_q[1], stat_s_q[2]);

  // Settled levels
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cclk_q <= 1'b0;
      uclk_q <= 1'b0;
      req_q <= 1'b1;
      stat_q <= 1'b0;
    end else begin
      cclk_q <= cclk_d;
      uclk_q <= uclk_d;
      req_q <= req_d;
      stat_q <= stat_d;
    end
  end

  logic cclk_rise; // Config clock rising edge seen
  logic cclk_fall; // Config clock falling edge seen
  logic uclk_rise; // User clock rising edge seen
  logic req_fall; // Request went low

  assign cclk_rise = cclk_d & ~cclk_q;
  assign cclk_fall = ~cclk_d & cclk_q;
  assign uclk_rise = uclk_d & ~uclk_q;
  assign req_fall = ~req_d & req_q;

  // ****************************************************************
  // Register file
  // ****************************************************************

  logic [5:0] ctrl_q; // Control fields
  logic [31:0] exp_words_q; // Image length in words
  logic [31:0] exp_check_q; // Expected XOR of raw words
  logic [31:0] key_q; // Decryption key
  logic [31:0] count_q; // Words accepted
  logic [31:0] check_q; // Running XOR of raw words
  logic [31:0] last_word_q; // Last processed word
  logic error_q; // Image check failed
  logic [3:0] ratio_q; // Ratio fixed at load start
  logic wb_req; // New bus request
  ppcl_pkg::ppcl_state_t state_q; // Loader state

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Register writes, byte lanes honoured on wide registers
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_q <= ppcl_pkg::CTRL_RESET;
      exp_words_q <= 32'h0000_0000;
      exp_check_q <= 32'h0000_0000;
      key_q <= 32'h0000_0000;
    end else if (wb_req && wb_we_i) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          case (wb_adr_i)
            ppcl_pkg::REG_EXP_WORDS: exp_words_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            ppcl_pkg::REG_EXP_CHECK: exp_check_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            ppcl_pkg::REG_KEY: key_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            default: ;
          endcase
        end
      end
      if (wb_sel_i[0] && wb_adr_i == ppcl_pkg::REG_CTRL) begin
        ctrl_q <= wb_dat_i[5:0];
      end
    end
  end

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          ppcl_pkg::REG_CTRL: wb_dat_o <= {26'h0, ctrl_q};
          ppcl_pkg::REG_EXP_WORDS: wb_dat_o <= exp_words_q;
          ppcl_pkg::REG_EXP_CHECK: wb_dat_o <= exp_check_q;
          ppcl_pkg::REG_KEY: wb_dat_o <= key_q;
          ppcl_pkg::REG_STATUS: wb_dat_o <= {24'h0, ratio_q, error_q, state_q};
          ppcl_pkg::REG_WORD_COUNT: wb_dat_o <= count_q;
          ppcl_pkg::REG_LAST_WORD: wb_dat_o <= last_word_q;
          // Unmapped reads return zero
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Word intake and processing
  // ****************************************************************

  logic [2:0] phase_q; // Edge position inside a word group
  logic [31:0] work_q; // Word being processed
  logic last_phase; // Edge ends the group
  logic load_edge; // Config clock edge counted in load

  assign load_edge = cclk_rise && state_q == ppcl_pkg::PPCL_LOAD && !error_q;
  assign last_phase = phase_q == 3'(ratio_q - 4'h1);

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_q <= 3'h0;
    end else if (state_q != ppcl_pkg::PPCL_LOAD) begin
      phase_q <= 3'h0;
    end else if (load_edge) begin
      phase_q <= last_phase ? 3'h0 : phase_q + 3'h1;
    end
  end

  logic [31:0] raw_word; // Sampled word on active lanes
  logic [31:0] step_word; // One processing round
  logic [31:0] src_word; // Word entering this round

  assign raw_word = data_s3_q & lanes_f(ctrl_q[ppcl_pkg::CTRL_WIDTH_LSB +: 2]);
  assign src_word = (phase_q == 3'h0) ? raw_word : work_q;

  // Decrypt by key, decompress by byte rotate
  always_comb begin
    step_word = src_word;
    if (ctrl_q[ppcl_pkg::CTRL_SECURE_BIT]) begin
      step_word = step_word ^ key_q;
    end
    if (ctrl_q[ppcl_pkg::CTRL_DECOMP_BIT]) begin
      step_word = {step_word[23:0], step_word[31:24]};
    end
  end

  // Word latched on rising config clock edge
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      work_q <= 32'h0000_0000;
      count_q <= 32'h0000_0000;
      check_q <= 32'h0000_0000;
    end else if (req_fall) begin
      count_q <= 32'h0000_0000;
      check_q <= 32'h0000_0000;
    end else if (load_edge) begin
      // First edge loads the raw word, each later edge one round
      work_q <= (phase_q == 3'h0) ? raw_word : step_word;
      // New word only on first edge
      if (phase_q == 3'h0) begin
        count_q <= count_q + 32'h1;
        check_q <= check_q ^ raw_word;
      end
    end
  end

  // Processed word output on the group's last edge
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_word <= 32'h0000_0000;
      cfg_word_valid <= 1'b0;
      last_word_q <= 32'h0000_0000;
    end else begin
      cfg_word_valid <= load_edge && last_phase;
      if (load_edge && last_phase) begin
        cfg_word <= ratio_q == 4'h1 ? raw_word : step_word;
        last_word_q <= ratio_q == 4'h1 ? raw_word : step_word;
      end
    end
  end

  // ****************************************************************
  // Sequence control
  // ****************************************************************

  logic [31:0] timer_q; // General cycle timer
  logic [13:0] edges_q; // Edge counter for done and init
  logic group_done; // Final group finished
  logic usr_wait_q; // User clock enable wait passed

  assign group_done = cfg_word_valid && count_q == exp_words_q;

  // Main state machine
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= ppcl_pkg::PPCL_POR;
      timer_q <= 32'h0000_0000;
      edges_q <= 14'h0000;
      error_q <= 1'b0;
      usr_wait_q <= 1'b0;
      ratio_q <= 4'h1;
    end else if (req_fall) begin
      state_q <= ppcl_pkg::PPCL_CLEAR;
      timer_q <= 32'h0000_0000;
      error_q <= 1'b0;
    end else begin
      case (state_q)
        ppcl_pkg::PPCL_POR: begin
          timer_q <= timer_q + 32'h1;
          if (timer_q >= POR_CYCLES - 1) begin
            state_q <= ppcl_pkg::PPCL_CLEAR;
            timer_q <= 32'h0000_0000;
          end
        end
        // Status low at least 268 us
        ppcl_pkg::PPCL_CLEAR: begin
          if (timer_q < ppcl_pkg::STATUS_MIN_CYC) begin
            timer_q <= timer_q + 32'h1;
          end
          if (timer_q >= ppcl_pkg::STATUS_MIN_CYC - 1 && req_q) begin
            state_q <= ppcl_pkg::PPCL_LOAD;
            ratio_q <= ratio_f(ctrl_q[ppcl_pkg::CTRL_WIDTH_LSB +: 2],
                               ctrl_q[ppcl_pkg::CTRL_DECOMP_BIT],
                               ctrl_q[ppcl_pkg::CTRL_SECURE_BIT]);
          end
        end
        ppcl_pkg::PPCL_LOAD: begin
          edges_q <= 14'h0000;
          if (group_done) begin
            if (check_q == exp_check_q) begin
              state_q <= ppcl_pkg::PPCL_DONE;
            end else begin
              state_q <= ppcl_pkg::PPCL_ERROR;
              error_q <= 1'b1;
            end
          end
        end
        ppcl_pkg::PPCL_DONE: begin
          if (cclk_fall) begin
            edges_q <= edges_q + 14'h1;
          end
          if (edges_q == 14'(ppcl_pkg::DONE_FALL_EDGES)) begin
            state_q <= ppcl_pkg::PPCL_INIT;
            edges_q <= 14'h0000;
            timer_q <= 32'h0000_0000;
            usr_wait_q <= 1'b0;
          end
        end
        ppcl_pkg::PPCL_INIT: begin
          timer_q <= timer_q + 32'h1;
          if (ctrl_q[ppcl_pkg::CTRL_USRCLK_BIT]) begin
            // Enable user clock, count 8576 periods
            if (timer_q >= ppcl_pkg::CU_CYC - 1) begin
              usr_wait_q <= 1'b1;
            end
            if (usr_wait_q && uclk_rise) begin
              edges_q <= edges_q + 14'h1;
            end
            if (edges_q == 14'(ppcl_pkg::USER_INIT_PERIODS)) begin
              state_q <= ppcl_pkg::PPCL_USER;
            end
          end else if (timer_q >= ppcl_pkg::INIT_OSC_CYC - 1) begin
            state_q <= ppcl_pkg::PPCL_USER;
          end
        end
        // User mode and error wait for a new request
        ppcl_pkg::PPCL_USER: ;
        ppcl_pkg::PPCL_ERROR: ;
        default: state_q <= ppcl_pkg::PPCL_POR;
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************

  logic status_low; // Loader pulls status low
  logic complete; // Image accepted

  // Status low in power-up, clear and error states, and on request fall
  assign status_low = state_q == ppcl_pkg::PPCL_POR || state_q == ppcl_pkg::PPCL_CLEAR
                      || state_q == ppcl_pkg::PPCL_ERROR || req_fall;
  assign complete = state_q == ppcl_pkg::PPCL_DONE || state_q == ppcl_pkg::PPCL_INIT
                    || state_q == ppcl_pkg::PPCL_USER;

  // Registered pin levels
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      loader_status_n_oe <= 1'b1;
      load_complete <= 1'b0;
      init_done_oe <= 1'b0;
      init_done_out <= 1'b0;
    end else begin
      loader_status_n_oe <= status_low;
      load_complete <= complete && !req_fall;
      // Init done low until user mode
      init_done_oe <= ctrl_q[ppcl_pkg::CTRL_INITDONE_BIT] && (complete && !req_fall);
      init_done_out <= state_q == ppcl_pkg::PPCL_USER && !req_fall;
    end
  end

  // Open-drain status pin only ever pulls low
  assign loader_status_n_out = 1'b0;

endmodule

`default_nettype wire

// ---- bench/ppcl_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Loader pin checker
// ****************************************
module ppcl_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic config_clock,
  input wire logic reload_request_n,
  input wire logic loader_status_n_oe,
  input wire logic load_complete,
  input wire logic init_done_out,
  input wire logic cfg_word_valid
);
  logic [15:0] low_q; // Cycles status pulled low
  logic [3:0] age_q; // Cycles since link rising edge
  logic [19:0] done_q; // Cycles since completion rose
  logic cc_q; // Last link clock sample
  logic lc_q; // Last completion sample
  default clocking ck @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Length of the status low run, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) low_q <= 16'h0000;
    else if (!loader_status_n_oe) low_q <= 16'h0000;
    else if (low_q != 16'hFFFF) low_q <= low_q + 16'h0001;
  end
  // Previous samples for edge finding
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cc_q <= 1'b0;
    else cc_q <= config_clock;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) lc_q <= 1'b0;
    else lc_q <= load_complete;
  end
  // Age of the last link rising edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) age_q <= 4'hF;
    else if (config_clock && !cc_q) age_q <= 4'h0;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  end
  // Age of the completion rise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) done_q <= 20'h00000;
    else if (load_complete && !lc_q) done_q <= 20'h00000;
    else if (done_q != 20'hFFFFF) done_q <= done_q + 20'h00001;
  end
  property p_req_status;
    $fell(reload_request_n) |-> ##[0:6] loader_status_n_oe;
  endproperty
  a_req_status: assert property (p_req_status) else $error("status late");
  property p_req_done;
    $fell(reload_request_n) |-> ##[0:6] !load_complete;
  endproperty
  a_req_done: assert property (p_req_done) else $error("completion late");
  property p_por;
    $rose(rst_n) |-> loader_status_n_oe [*8];
  endproperty
  a_por: assert property (p_por) else $error("status up too soon");
  property p_low_min;
    $fell(loader_status_n_oe) |-> low_q >= 16'(ppcl_pkg::STATUS_MIN_CYC);
  endproperty
  a_low_min: assert property (p_low_min) else $error("status pulse short");
  property p_done_low;
    loader_status_n_oe |-> !load_complete;
  endproperty
  a_done_low: assert property (p_done_low) else $error("completion early");
  property p_word_edge;
    cfg_word_valid |-> age_q <= 4'h8;
  endproperty
  a_word_edge: assert property (p_word_edge) else $error("word without edge");
  property p_init_min;
    $rose(init_done_out) |-> done_q >= 20'(ppcl_pkg::INIT_OSC_CYC);
  endproperty
  a_init_min: assert property (p_init_min) else $error("init too fast");
  property p_user;
    init_done_out |-> load_complete && !loader_status_n_oe;
  endproperty
  a_user: assert property (p_user) else $error("user mode pins wrong");
endmodule

bind ppcl_loader ppcl_checker u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .config_clock(config_clock),
  .reload_request_n(reload_request_n),
  .loader_status_n_oe(loader_status_n_oe),
  .load_complete(load_complete),
  .init_done_out(init_done_out),
  .cfg_word_valid(cfg_word_valid)
);
`default_nettype wire

// ---- bench/ppcl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Configuration host model
// ****************************************
module ppcl_host_model (
  input wire logic clock,
  input wire logic status_wire_n,
  output logic config_clock,
  output logic [31:0] config_data,
  output logic reload_request_n
);
  // Link clock parked low, never floating
  initial begin
    config_clock = 1'b0;
    config_data = 32'h0000_0000;
    reload_request_n = 1'b1;
  end
  task automatic reload();
    @(posedge clock);
    reload_request_n <= 1'b0;
    repeat (30) @(posedge clock);
    reload_request_n <= 1'b1;
  endtask
  // Watch status, then 3 us more
  task automatic wait_ready(output logic ok);
    int n;
    for (n = 0; n < 4000 && status_wire_n !== 1'b1; n++) @(posedge clock);
    ok = (n < 4000);
    repeat (30) @(posedge clock);
  endtask
  // Word held for n link cycles of 800 ns
  task automatic cycles(input logic [31:0] w, input int n);
    @(posedge clock);
    config_data <= w;
    repeat (n) begin
      repeat (4) @(posedge clock);
      config_clock <= 1'b1;
      repeat (4) @(posedge clock);
      config_clock <= 1'b0;
    end
    config_data <= ~w;
  endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Loader testbench
// ****************************************
module testbench;
  logic clock, rst_n, cyc, stb, we, ack, cclk, req_n, st_out, st_oe; // Pins
  logic lc, ido, idoe, cvalid; // Loader outputs
  logic [7:0] adr; // Bus address
  logic [3:0] sel; // Byte lanes
  logic [31:0] wdat, rdat, cdata, cword; // Data paths
  logic [31:0] got[$]; // Processed words seen
  logic [1:0] ucnt; // User clock divider
  wire st_wire; // Open-drain status with pull-up
  int fail_count, comparisons;
  assign st_wire = st_oe ? st_out : 1'b1;
  ppcl_loader #(.POR_CYCLES(10)) dut (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .config_clock(cclk), .config_data(cdata), .reload_request_n(req_n),
    .loader_status_n_in(st_wire), .loader_status_n_out(st_out),
    .loader_status_n_oe(st_oe), .load_complete(lc), .user_init_clock(ucnt[1]),
    .init_done_out(ido), .init_done_oe(idoe), .cfg_word(cword), .cfg_word_valid(cvalid)
  );
  ppcl_host_model host (
    .clock(clock), .status_wire_n(st_wire), .config_clock(cclk),
    .config_data(cdata), .reload_request_n(req_n)
  );
  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // User init clock, 400 ns period
  always @(posedge clock) ucnt <= ucnt + 2'h1;
  // Collect every processed word
  always @(posedge clock) if (cvalid === 1'b1) got.push_back(cword);
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  // One classic bus cycle, held until acknowledged
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({31'h0, n < 20}, 32'h1, "bus answer");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  // Set mode, request reload, wait for status release
  task automatic restart(input logic [31:0] c);
    logic ok;
    wr(ppcl_pkg::REG_CTRL, c);
    host.reload();
    host.wait_ready(ok);
    chk({31'h0, ok}, 32'h1, "status release");
  endtask
  // Reset values and an unmapped address
  task automatic t_power();
    logic [31:0] q;
    logic ok;
    chk({30'h0, st_oe, lc}, 32'h2, "pins out of reset");
    wb(1'b0, ppcl_pkg::REG_CTRL, 32'h0, q);
    chk(q, 32'h0, "control reset");
    wr(8'h1C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h1C, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    host.wait_ready(ok);
    chk({31'h0, ok}, 32'h1, "first release");
  endtask
  // Ratio of every width and feature mix, restarting mid-load
  task automatic t_ratio();
    int exp_r[12] = '{1, 1, 2, 2, 1, 2, 4, 4, 1, 4, 8, 8};
    logic [31:0] q;
    for (int i = 0; i < 12; i++) begin
      restart(32'(i / 4) | 32'(((i % 4) / 2) * 4) | 32'((i % 2) * 8));
      wb(1'b0, ppcl_pkg::REG_STATUS, 32'h0, q);
      chk({24'h0, q[7:0]}, 32'(exp_r[i] * 16 + 3), "ratio");
    end
  endtask
  // Secure 32-bit image, oscillator initialisation
  task automatic t_good();
    logic [31:0] w[3] = '{32'h1234_5678, 32'h9ABC_DEF0, 32'h0F1E_2D3C};
    logic [31:0] k = 32'h3C5A_96E1;
    logic [31:0] q;
    realtime t0;
    int n;
    wr(ppcl_pkg::REG_KEY, k);
    wr(ppcl_pkg::REG_EXP_WORDS, 32'h3);
    wr(ppcl_pkg::REG_EXP_CHECK, w[0] ^ w[1] ^ w[2]);
    restart(32'h2A);
    got.delete();
    foreach (w[i]) host.cycles(w[i], 4);
    for (n = 0; n < 50 && lc !== 1'b1; n++) @(posedge clock);
    t0 = $realtime;
    @(posedge clock);
    chk({29'h0, lc, idoe, ido}, 32'h6, "image accepted");
    host.cycles(32'h0, 2);
    for (n = 0; n < 5000 && ido !== 1'b1; n++) @(posedge clock);
    chk({31'h0, ($realtime - t0) >= 175000.0 && ($realtime - t0) <= 437000.0},
        32'h1, "init delay");
    chk(32'(got.size()), 32'h3, "word count");
    foreach (w[i]) chk(got[i], w[i] ^ k, "decrypted word");
    wb(1'b0, ppcl_pkg::REG_STATUS, 32'h0, q);
    chk({28'h0, st_wire, lc, q[2:0] == 3'h7, ido}, 32'hF, "user mode");
  endtask
  // Bad checksum in 8-bit decompress mode, then recovery
  task automatic t_bad();
    logic [31:0] q;
    int n;
    wr(ppcl_pkg::REG_EXP_WORDS, 32'h2);
    wr(ppcl_pkg::REG_EXP_CHECK, 32'h0);
    restart(32'h04);
    got.delete();
    host.cycles(32'hA5A5_12C3, 2);
    host.cycles(32'h5A5A_0F3C, 2);
    for (n = 0; n < 50 && st_oe !== 1'b1; n++) @(posedge clock);
    chk(got[0], 32'h0000_C300, "masked rotated word");
    chk(got[1], 32'h0000_3C00, "masked rotated word");
    wb(1'b0, ppcl_pkg::REG_STATUS, 32'h0, q);
    chk({23'h0, lc, q[7:0]}, 32'h2D, "error state");
    restart(32'h0);
    wb(1'b0, ppcl_pkg::REG_STATUS, 32'h0, q);
    chk({24'h0, q[7:0]}, 32'h13, "recovered");
  endtask
  // Byte image, user clock initialisation
  task automatic t_user();
    logic [31:0] q;
    realtime t0, dt;
    int n;
    wr(ppcl_pkg::REG_EXP_WORDS, 32'h1);
    wr(ppcl_pkg::REG_EXP_CHECK, 32'h5A);
    restart(32'h10);
    got.delete();
    host.cycles(32'h0000_A55A, 1);
    for (n = 0; n < 50 && lc !== 1'b1; n++) @(posedge clock);
    t0 = $realtime;
    host.cycles(32'h0, 2);
    for (n = 0; n < 40000 && ido !== 1'b1; n++) @(posedge clock);
    dt = $realtime - t0;
    chk({31'h0, dt >= ppcl_pkg::USER_INIT_PERIODS * 400.0}, 32'h1, "user init short");
    chk({31'h0, dt <= 3440000.0}, 32'h1, "user init late");
    chk(got[0], 32'h0000_005A, "raw byte word");
    wb(1'b0, ppcl_pkg::REG_WORD_COUNT, 32'h0, q);
    chk(q, 32'h1, "word count register");
    wb(1'b0, ppcl_pkg::REG_LAST_WORD, 32'h0, q);
    chk(q, 32'h0000_005A, "last word register");
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #9000000;
    fail_count++;
    test_done();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    ucnt = 2'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_power();
    t_ratio();
    t_good();
    t_bad();
    t_user();
    test_done();
  end
endmodule
`default_nettype wire
